/* include/bridge_hdr_pkg.sv */
// constants and carriers for the bridge status / class / scratch header slice
package bridge_hdr_pkg;

  // printed byte offsets of the registers held here
  localparam logic [11:0] STATUS_OFS = 12'h006;
  localparam logic [11:0] REV_OFS = 12'h008;
  localparam logic [11:0] CLASS_OFS = 12'h009;
  localparam logic [11:0] LINE_OFS = 12'h00c;
  localparam logic [11:0] PLT_OFS = 12'h00d;

  // field positions inside the 16-bit status register
  localparam int IRQ_PEND_BIT = 3;
  localparam int CAP_BIT = 4;
  localparam int MDP_BIT = 8;
  localparam int TARGET_ABORT_BIT = 11;
  localparam int SYS_ERR_BIT = 14;
  localparam int POISON_BIT = 15;

  // index of each sticky flag inside the flag vector
  localparam int FLG_MDP = 0;
  localparam int FLG_SYS_ERR = 1;
  localparam int FLG_POISON = 2;
  localparam int FLG_COUNT = 3;

  // fixed and reset values
  localparam logic [23:0] CLASS_CODE = 24'h06_0400;
  localparam logic [7:0] LINE_RESET = 8'h00;
  localparam logic [7:0] PLT_VALUE = 8'h00;
  localparam logic [7:0] REV_RESET = 8'h00;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // one configuration access, dword aligned with byte enables
  typedef struct packed {
    logic req;
    logic wr;
    logic [11:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cfg_req_t;

  // error and poison events seen by the port, one-cycle pulses
  typedef struct packed {
    logic poison_cpl_rx;
    logic poison_wr_tx;
    logic poison_tlp_rx;
    logic err_msg_sent;
    logic err_detect;
  } err_events_t;

  // sources of this function's own legacy interrupt, levels
  typedef struct packed {
    logic hotplug_irq;
    logic internal_parity_err;
    logic cfg_access_err;
  } irq_sources_t;

endpackage

/* hdl/w1c_flags.sv */
// vector of sticky write-one-to-clear flags, set beats clear
`timescale 1ns/100ps
module w1c_flags import bridge_hdr_pkg::*; #(
  parameter int WIDTH = 3
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] set,
  input wire logic [WIDTH-1:0] clr,
  output logic [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] q;
  } w1c_state_t;

  w1c_state_t st;
  w1c_state_t next_st;

  // set is or-ed after the clear so a coincident event survives
  always_comb begin
    next_st = st;
    next_st.q = (st.q & ~clr) | set;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.q;

  property p_set_wins;
    @(posedge mclk) disable iff (!rst_b)
    (set != '0) |=> ((q & $past(set)) == $past(set));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set flag not held");

  property p_zero_write_keeps;
    @(posedge mclk) disable iff (!rst_b)
    (set == '0 && clr == '0) |=> (q == $past(q));
  endproperty
  a_zero_write_keeps: assert property (p_zero_write_keeps) else $error("flag moved without cause");

  property p_clear_works;
    @(posedge mclk) disable iff (!rst_b)
    (set == '0 && clr != '0) |=> ((q & $past(clr)) == '0);
  endproperty
  a_clear_works: assert property (p_clear_works) else $error("write one did not clear");

endmodule // w1c_flags

/* hdl/bridge_config_status_header.sv */
// status, revision, class, cache line and latency slice of a bridge config header
`timescale 1ns/100ps
module bridge_config_status_header import bridge_hdr_pkg::*; #(
  parameter logic [7:0] REV_DEFAULT = REV_RESET // arbitrary value
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire cfg_req_t cfg,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  input wire logic is_upstream,
  input wire logic rev_lock,
  input wire logic parity_report_enable,
  input wire logic system_error_enable,
  input wire err_events_t ev,
  input wire irq_sources_t irq,
  output logic err_msg_req
);

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [7:0] line_size_scratch;
    logic [7:0] revision_number;
    logic err_msg_req;
  } hdr_state_t;

  hdr_state_t st;
  hdr_state_t next_st;
  logic [FLG_COUNT-1:0] flag_set;
  logic [FLG_COUNT-1:0] flag_clr;
  logic [FLG_COUNT-1:0] flags;
  logic legacy_irq_pending;
  logic [15:0] bridge_status;
  logic hit_status;
  logic hit_rev;
  logic hit_cls;

  // true when the access targets the dword holding the given byte offset
  function automatic logic dword_hit(input logic [11:0] a, input logic [11:0] ofs);
    dword_hit = (a[11:2] == ofs[11:2]);
  endfunction

  assign hit_status = dword_hit(cfg.addr, STATUS_OFS);
  assign hit_rev = dword_hit(cfg.addr, REV_OFS);
  assign hit_cls = dword_hit(cfg.addr, LINE_OFS);

  // own interrupt only; forwarded INTx has no input here at all
  always_comb begin
    if (is_upstream) begin
      legacy_irq_pending = irq.internal_parity_err | irq.cfg_access_err;
    end else begin
      legacy_irq_pending = irq.hotplug_irq;
    end
  end

  // sticky error events
  always_comb begin
    flag_set = '0;
    flag_set[FLG_MDP] = parity_report_enable & (ev.poison_cpl_rx | ev.poison_wr_tx);
    flag_set[FLG_SYS_ERR] = system_error_enable & ev.err_msg_sent;
    flag_set[FLG_POISON] = ev.poison_tlp_rx;
  end

  // status high byte sits in lane 3 of its dword; zero bits are ignored
  always_comb begin
    flag_clr = '0;
    if (cfg.req && cfg.wr && hit_status && cfg.be[3]) begin
      flag_clr[FLG_MDP] = cfg.wdata[16+MDP_BIT];
      flag_clr[FLG_SYS_ERR] = cfg.wdata[16+SYS_ERR_BIT];
      flag_clr[FLG_POISON] = cfg.wdata[16+POISON_BIT];
    end
  end

  w1c_flags #(
    .WIDTH(FLG_COUNT)
  ) u_flags (
    .mclk(mclk),
    .rst_b(rst_b),
    .set(flag_set),
    .clr(flag_clr),
    .q(flags)
  );

  // every field not listed stays zero: aborts, timing, reserved
  always_comb begin
    bridge_status = 16'h0000;
    bridge_status[IRQ_PEND_BIT] = legacy_irq_pending;
    bridge_status[CAP_BIT] = 1'b1;
    bridge_status[MDP_BIT] = flags[FLG_MDP];
    bridge_status[SYS_ERR_BIT] = flags[FLG_SYS_ERR];
    bridge_status[POISON_BIT] = flags[FLG_POISON];
  end

  // access decode, writes and read data; every request answered next cycle
  always_comb begin
    next_st = st;
    next_st.ack = cfg.req;
    next_st.err_msg_req = ev.err_detect & system_error_enable;
    if (cfg.req && cfg.wr) begin
      if (hit_rev && cfg.be[0] && !rev_lock) begin
        next_st.revision_number = cfg.wdata[7:0];
      end
      if (hit_cls && cfg.be[0]) begin
        next_st.line_size_scratch = cfg.wdata[7:0];
      end
    end
    if (cfg.req && !cfg.wr) begin
      if (hit_status) begin
        next_st.rdata = {bridge_status, 16'h0000}; // command half lives elsewhere
      end else if (hit_rev) begin
        next_st.rdata = {CLASS_CODE, st.revision_number};
      end else if (hit_cls) begin
        next_st.rdata = {16'h0000, PLT_VALUE, st.line_size_scratch};
      end else begin
        next_st.rdata = RDATA_RESET;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st.ack <= 1'b0;
      st.rdata <= RDATA_RESET;
      st.line_size_scratch <= LINE_RESET;
      st.revision_number <= REV_DEFAULT;
      st.err_msg_req <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign cfg_ack = st.ack;
  assign cfg_rdata = st.rdata;
  assign err_msg_req = st.err_msg_req;

  // helper: the answer in this cycle belongs to a read of the given dword
  logic rd_status_q;
  logic rd_rev_q;
  logic rd_cls_q;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rd_status_q <= 1'b0;
      rd_rev_q <= 1'b0;
      rd_cls_q <= 1'b0;
    end else begin
      rd_status_q <= cfg.req & ~cfg.wr & hit_status;
      rd_rev_q <= cfg.req & ~cfg.wr & hit_rev;
      rd_cls_q <= cfg.req & ~cfg.wr & hit_cls;
    end
  end

  property p_cap_one;
    @(posedge mclk) disable iff (!rst_b)
    rd_status_q |-> (cfg_rdata[16+CAP_BIT] == 1'b1);
  endproperty
  a_cap_one: assert property (p_cap_one) else $error("capabilities bit not one");

  property p_zero_fields;
    @(posedge mclk) disable iff (!rst_b)
    rd_status_q |-> (cfg_rdata[29:25] == 5'h00 && cfg_rdata[23:21] == 3'h0 && cfg_rdata[18:16] == 3'h0);
  endproperty
  a_zero_fields: assert property (p_zero_fields) else $error("fixed zero status field set");

  property p_irq_follows;
    @(posedge mclk) disable iff (!rst_b)
    (cfg.req && !cfg.wr && hit_status) |=>
      (cfg_rdata[16+IRQ_PEND_BIT] == ($past(is_upstream)
                                      ? ($past(irq.internal_parity_err) | $past(irq.cfg_access_err))
                                      : $past(irq.hotplug_irq)));
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("interrupt status wrong");

  property p_mdp_gated;
    @(posedge mclk) disable iff (!rst_b)
    (!parity_report_enable && !flags[FLG_MDP]) |=> !flags[FLG_MDP];
  endproperty
  a_mdp_gated: assert property (p_mdp_gated) else $error("master poison set while disabled");

  property p_mdp_sets;
    @(posedge mclk) disable iff (!rst_b)
    (parity_report_enable && ev.poison_cpl_rx) |=> flags[FLG_MDP];
  endproperty
  a_mdp_sets: assert property (p_mdp_sets) else $error("master poison not set");

  property p_sse_sets;
    @(posedge mclk) disable iff (!rst_b)
    (system_error_enable && ev.err_msg_sent) |=> flags[FLG_SYS_ERR] ##0 (bridge_status[SYS_ERR_BIT] == 1'b1);
  endproperty
  a_sse_sets: assert property (p_sse_sets) else $error("system error flag not set");

  property p_dpe_sets;
    @(posedge mclk) disable iff (!rst_b)
    ev.poison_tlp_rx |=> flags[FLG_POISON];
  endproperty
  a_dpe_sets: assert property (p_dpe_sets) else $error("detected poison not set");

  property p_class_code;
    @(posedge mclk) disable iff (!rst_b)
    rd_rev_q |-> (cfg_rdata[31:8] == CLASS_CODE);
  endproperty
  a_class_code: assert property (p_class_code) else $error("class code wrong");

  property p_latency_zero;
    @(posedge mclk) disable iff (!rst_b)
    rd_cls_q |-> (cfg_rdata[15:8] == PLT_VALUE && cfg_rdata[31:16] == 16'h0000);
  endproperty
  a_latency_zero: assert property (p_latency_zero) else $error("latency timer not zero");

  property p_cls_store;
    @(posedge mclk) disable iff (!rst_b)
    (cfg.req && cfg.wr && hit_cls && cfg.be[0]) ##1 (cfg.req && !cfg.wr && hit_cls)
      |=> (cfg_rdata[7:0] == $past(cfg.wdata[7:0], 2));
  endproperty
  a_cls_store: assert property (p_cls_store) else $error("cache line size not stored");

  property p_rev_lock;
    @(posedge mclk) disable iff (!rst_b)
    (cfg.req && cfg.wr && hit_rev && rev_lock) |=> $stable(st.revision_number);
  endproperty
  a_rev_lock: assert property (p_rev_lock) else $error("locked revision changed");

  property p_err_gate;
    @(posedge mclk) disable iff (!rst_b)
    err_msg_req |-> $past(system_error_enable) && $past(ev.err_detect);
  endproperty
  a_err_gate: assert property (p_err_gate) else $error("error reported while disabled");

  property p_ack_next;
    @(posedge mclk) disable iff (!rst_b)
    cfg.req |=> cfg_ack;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("access not answered");

  property p_abort_zero;
    @(posedge mclk) disable iff (!rst_b)
    rd_status_q |-> (cfg_rdata[16+TARGET_ABORT_BIT] == 1'b0);
  endproperty
  a_abort_zero: assert property (p_abort_zero) else $error("target abort bit set");

endmodule // bridge_config_status_header

/* bench/cfg_sw_model.sv */
// configuration software model issuing single dword accesses to the header slice
`timescale 1ns/100ps
module cfg_sw_model import bridge_hdr_pkg::*; (
  input wire logic mclk,
  output cfg_req_t cfg,
  input wire logic cfg_ack,
  input wire logic [31:0] cfg_rdata
);
  initial cfg = '0;

  // entered just after a falling edge; the answer is taken at the next falling edge
  // the lines are left as they are so a next access may follow back to back
  task automatic access(input logic wr, input logic [11:0] addr, input logic [3:0] be,
      input logic [31:0] wdata, output logic [31:0] rdata, output logic acked);
    cfg = '{req: 1'b1, wr: wr, addr: addr, be: be, wdata: wdata};
    @(negedge mclk);
    acked = cfg_ack;
    rdata = cfg_rdata;
  endtask

  // released lines show the inverse so stale values never pass for live ones
  task automatic idle();
    cfg = '{req: 1'b0, wr: ~cfg.wr, addr: ~cfg.addr, be: ~cfg.be, wdata: ~cfg.wdata};
    @(negedge mclk);
  endtask
endmodule // cfg_sw_model

/* bench/tb_bridge_config_status_header.sv */
// self-checking bench for the bridge status, class and scratch header slice
`timescale 1ns/100ps
module tb_bridge_config_status_header import bridge_hdr_pkg::*;;
  typedef struct packed {logic wr; logic lock; logic [11:0] addr; logic [3:0] be; logic [31:0] data;} row_t;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic is_upstream = 1'b0;
  logic rev_lock = 1'b0;
  logic parity_report_enable = 1'b0;
  logic system_error_enable = 1'b0;
  err_events_t ev = '0;
  irq_sources_t irq = '0;
  cfg_req_t cfg;
  logic cfg_ack;
  logic err_msg_req;
  logic [31:0] cfg_rdata;
  int err_count = 0;
  int cmp_count = 0;
  // plain accesses: writes carry data, reads carry the expected dword
  row_t rows [15] = '{
    '{1'b0, 1'b0, 12'h004, 4'hf, 32'h0010_0000}, '{1'b1, 1'b0, 12'h004, 4'hf, 32'hffff_ffff},
    '{1'b0, 1'b0, 12'h004, 4'hf, 32'h0010_0000}, '{1'b0, 1'b0, 12'h008, 4'hf, 32'h0604_003c},
    '{1'b0, 1'b0, 12'h00c, 4'hf, 32'h0000_0000}, '{1'b1, 1'b0, 12'h00c, 4'hf, 32'hffff_ffa5},
    '{1'b0, 1'b0, 12'h00c, 4'hf, 32'h0000_00a5}, '{1'b1, 1'b0, 12'h00c, 4'h0, 32'h0000_0077},
    '{1'b0, 1'b0, 12'h00c, 4'hf, 32'h0000_00a5}, '{1'b1, 1'b0, 12'h008, 4'h1, 32'hffff_ffc3},
    '{1'b0, 1'b0, 12'h008, 4'hf, 32'h0604_00c3}, '{1'b1, 1'b1, 12'h008, 4'h1, 32'h0000_0011},
    '{1'b0, 1'b0, 12'h008, 4'hf, 32'h0604_00c3}, '{1'b1, 1'b0, 12'h010, 4'hf, 32'hffff_ffff},
    '{1'b0, 1'b0, 12'h010, 4'hf, 32'h0000_0000}};

  always #5 mclk = ~mclk;

  bridge_config_status_header #(.REV_DEFAULT(8'h3c)) uut (.mclk(mclk), .rst_b(rst_b), .cfg(cfg),
    .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .is_upstream(is_upstream), .rev_lock(rev_lock),
    .parity_report_enable(parity_report_enable), .system_error_enable(system_error_enable),
    .ev(ev), .irq(irq), .err_msg_req(err_msg_req));

  cfg_sw_model host (.mclk(mclk), .cfg(cfg), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // b2b keeps the request lines up so the next access follows at the very next edge
  task automatic rd(input logic [11:0] addr, input logic [31:0] exp, input bit b2b = 1'b0);
    logic [31:0] d;
    logic a;
    host.access(1'b0, addr, 4'hf, 32'h0000_0000, d, a);
    check("cfg_ack", 32'h0000_0001, {31'h0, a});
    check($sformatf("read %h", addr), exp, d);
    if (!b2b) begin
      host.idle();
    end
  endtask

  task automatic wr(input logic [11:0] addr, input logic [3:0] be, input logic [31:0] data, input bit b2b = 1'b0);
    logic [31:0] d;
    logic a;
    host.access(1'b1, addr, be, data, d, a);
    check("cfg_ack", 32'h0000_0001, {31'h0, a});
    if (!b2b) begin
      host.idle();
    end
  endtask

  // one-cycle event pulse; the gated error request must follow one edge later
  // a quiet cycle follows so the next pulse never rewrites ev in the same step
  task automatic pulse(input logic [4:0] e, input logic exp_msg);
    ev = e;
    @(negedge mclk);
    ev = '0;
    check("err_msg_req", {31'h0, exp_msg}, {31'h0, err_msg_req});
    @(negedge mclk);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 50 us
  initial begin
    #50000;
    err_count++;
    close_out();
  end

  initial begin
    repeat (16) @(negedge mclk);
    rst_b = 1'b1;
    @(negedge mclk);
    foreach (rows[i]) begin
      rev_lock = rows[i].lock;
      if (rows[i].wr) begin
        wr(rows[i].addr, rows[i].be, rows[i].data, 1'b1);
      end else begin
        rd(rows[i].addr, rows[i].data, 1'b1);
      end
    end
    host.idle();
    rev_lock = 1'b0;
    $display("test register rows done");
    // poison and error flags, enables low then high
    pulse(5'h10, 1'b0);
    pulse(5'h08, 1'b0);
    rd(12'h004, 32'h0010_0000);
    parity_report_enable = 1'b1;
    pulse(5'h10, 1'b0);
    rd(12'h004, 32'h0110_0000);
    parity_report_enable = 1'b0;
    pulse(5'h04, 1'b0);
    rd(12'h004, 32'h8110_0000);
    pulse(5'h02, 1'b0);
    rd(12'h004, 32'h8110_0000);
    system_error_enable = 1'b1;
    pulse(5'h02, 1'b0);
    rd(12'h004, 32'hc110_0000);
    pulse(5'h01, 1'b1);
    system_error_enable = 1'b0;
    pulse(5'h01, 1'b0);
    $display("test event flags done");
    // clearing: zeros keep, ones clear, a coincident set wins
    wr(12'h004, 4'h8, 32'h0000_0000);
    rd(12'h004, 32'hc110_0000);
    wr(12'h004, 4'h8, 32'h4100_0000);
    rd(12'h004, 32'h8010_0000);
    ev.poison_tlp_rx = 1'b1;
    wr(12'h004, 4'h8, 32'h8000_0000, 1'b1);
    ev = '0;
    rd(12'h004, 32'h8010_0000);
    wr(12'h004, 4'h8, 32'h8000_0000);
    rd(12'h004, 32'h0010_0000);
    $display("test clearing done");
    // interrupt status follows this function's own sources per port role
    irq.hotplug_irq = 1'b1;
    rd(12'h004, 32'h0018_0000);
    irq = '0;
    rd(12'h004, 32'h0010_0000);
    irq = '{hotplug_irq: 1'b0, internal_parity_err: 1'b1, cfg_access_err: 1'b0};
    rd(12'h004, 32'h0010_0000);
    is_upstream = 1'b1;
    rd(12'h004, 32'h0018_0000);
    irq = '{hotplug_irq: 1'b0, internal_parity_err: 1'b0, cfg_access_err: 1'b1};
    rd(12'h004, 32'h0018_0000);
    irq = '{hotplug_irq: 1'b1, internal_parity_err: 1'b0, cfg_access_err: 1'b0};
    rd(12'h004, 32'h0010_0000);
    irq = '0;
    $display("test interrupt status done");
    // reset in mid-run returns scratch and flags to their reset values
    pulse(5'h04, 1'b0);
    rst_b = 1'b0;
    repeat (2) @(negedge mclk);
    rst_b = 1'b1;
    @(negedge mclk);
    rd(12'h00c, 32'h0000_0000);
    rd(12'h004, 32'h0010_0000);
    rd(12'h008, 32'h0604_003c);
    $display("test second reset done");
    close_out();
  end
endmodule // tb_bridge_config_status_header
